// ===== core/mpt_pkg.sv
/*
  mpt_pkg: shared constants for the page translation block.
  assumes: included before all mpt_* modules.
*/
`default_nettype none
package mpt_pkg;
    // ----------------------------------------
    // register map (byte offsets on apb)
    // ----------------------------------------
    localparam logic [7:0] OFS_MSR = 8'h00;
    localparam logic [7:0] OFS_TBC = 8'h04;
    localparam logic [7:0] OFS_IST = 8'h08;
    localparam logic [7:0] OFS_IMSK = 8'h0c;
    localparam logic [7:0] OFS_FEA = 8'h10;
    localparam logic [7:0] OFS_SEG = 8'h40;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int MSR_IR = 0;
    localparam int MSR_DR = 1;
    localparam int MSR_PR = 2;
    localparam int SEG_KS = 29;
    localparam int SEG_KP = 28;
    localparam int IRQ_PF = 0;
    localparam int IRQ_PROT = 1;
    localparam int W0_V = 31;
    localparam int W0_H = 6;
    localparam int W1_R = 8;
    localparam int W1_C = 7;
    localparam int W1_WIMG = 3;
    // ----------------------------------------
    // reset values and sizes
    // ----------------------------------------
    localparam logic [2:0] MSR_RST = 3'h0;
    localparam logic [15:0] TBC_BASE_RST = 16'h0000;
    localparam logic [9:0] TBC_MASK_RST = 10'h000;
    localparam logic [3:0] WIMG_REAL = 4'h3;
    localparam int PAGE_BITS = 12;
    localparam int GROUP_ENTRIES = 8;
    localparam int ENTRY_BYTES = 8;
    localparam int GROUP_SHIFT = 6;
    localparam int NUM_SEG = 16;
endpackage
`default_nettype wire

// ===== core/mpt_pte_match.sv
/*
  mpt_pte_match: compares the first word of a table entry with the lookup key.
  assumes: word fetched from the current group, primary hash only.
*/
`timescale 1ns/1ps
`default_nettype none
module mpt_pte_match import mpt_pkg::*; (
    // entry word and key
    input wire logic [31:0] word0,
    input wire logic [23:0] vsid,
    input wire logic [5:0] api,
    // result
    output logic hit
);
    // ----------------------------------------
    // valid, primary, matching vsid and api
    // ----------------------------------------
    assign hit = word0[W0_V] && !word0[W0_H] && (word0[30:7] == vsid) && (word0[5:0] == api);
endmodule // mpt_pte_match
`default_nettype wire

// ===== core/mpt_prot_check.sv
/*
  mpt_prot_check: key and page-protection decision for one access.
  assumes: only consulted for relocated accesses.
*/
`timescale 1ns/1ps
`default_nettype none
module mpt_prot_check import mpt_pkg::*; (
    // keys and mode
    input wire logic supervisor_key,
    input wire logic user_key,
    input wire logic user_mode,
    // page protection and access
    input wire logic [1:0] pp,
    input wire logic store,
    output logic allow
);
    logic key;
    // ----------------------------------------
    // key selects the protection table row
    // ----------------------------------------
    assign key = user_mode ? user_key : supervisor_key;
    always_comb begin
        case (pp)
            2'h0: allow = !key;
            2'h1: allow = !key || !store;
            2'h2: allow = 1'b1;
            default: allow = !store;
        endcase
    end
endmodule // mpt_prot_check
`default_nettype wire

// ===== core/mpt_mmu.sv
/*
  mpt_mmu: page translation with history update, apb registers, interrupt.
  assumes: one request at a time from fetch/load-store logic on ref_clk;
  memory port holds ack for one cycle per request.
*/
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mpt_mmu import mpt_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // translation request
    input wire logic req_valid,
    input wire logic [31:0] req_ea,
    input wire logic req_store,
    input wire logic req_instr,
    output logic req_ready,
    // translation response
    output logic resp_valid,
    output logic [31:0] resp_pa,
    output logic resp_page_fault,
    output logic resp_prot_fault,
    output logic [3:0] resp_wimg,
    // page table memory port
    output logic mem_req,
    output logic [31:0] mem_addr,
    output logic mem_we,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // interrupt
    output logic irq
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH0 = 2'b01,
        ST_FETCH1 = 2'b11,
        ST_WRBACK = 2'b10
    } mpt_state_t;

    typedef struct packed {
        mpt_state_t state;
        logic [2:0] machine_state_reg;
        logic [15:0] base;
        logic [9:0] gmask;
        logic [NUM_SEG-1:0][25:0] seg;
        logic [1:0] ist;
        logic [1:0] imask;
        logic irq;
        logic [31:0] fault_ea;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic [31:0] ea;
        logic store;
        logic instr;
        logic [2:0] idx;
        logic [31:0] w1;
        logic mreq;
        logic [31:0] maddr;
        logic mwe;
        logic [31:0] mwdata;
        logic ready;
        logic rvalid;
        logic [31:0] rpa;
        logic rpf;
        logic rprot;
        logic [3:0] rwimg;
    } mpt_regs_t;

    mpt_regs_t q;
    mpt_regs_t d;
    logic hit;
    logic allow;
    logic [25:0] cur_seg;
    logic [31:0] grp_addr;
    logic [31:0] w1_new;
    logic ist_pf_set;

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    function automatic logic [2:0] reg_sel(input logic [7:0] a);
        if (a[7:6] == OFS_SEG[7:6]) begin
            reg_sel = 3'h6;
        end else if (a == OFS_MSR) begin
            reg_sel = 3'h1;
        end else if (a == OFS_TBC) begin
            reg_sel = 3'h2;
        end else if (a == OFS_IST) begin
            reg_sel = 3'h3;
        end else if (a == OFS_IMSK) begin
            reg_sel = 3'h4;
        end else if (a == OFS_FEA) begin
            reg_sel = 3'h5;
        end else begin
            reg_sel = 3'h0;
        end
    endfunction

    // ----------------------------------------
    // lookup helpers
    // ----------------------------------------
    assign cur_seg = q.seg[q.ea[31:28]];
    // primary hash picks one group; table size mask bounds the group count
    assign grp_addr = {q.base, (q.ea[21:12] ^ cur_seg[9:0]) & q.gmask, 6'h00};
    assign w1_new = q.w1 | (32'h1 << W1_R) | ({31'h0, q.store} << W1_C);

    mpt_pte_match u_match (
        .word0(mem_rdata),
        .vsid(cur_seg[23:0]),
        .api(q.ea[27:22]),
        .hit(hit)
    );

    mpt_prot_check u_prot (
        .supervisor_key(cur_seg[25]),
        .user_key(cur_seg[24]),
        .user_mode(q.machine_state_reg[MSR_PR]),
        .pp(mem_rdata[1:0]),
        .store(q.store),
        .allow(allow)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [2:0] sel;
        logic pf_ev;
        logic prot_ev;
        sel = reg_sel(paddr);
        pf_ev = 1'b0;
        prot_ev = 1'b0;
        d = q;
        d.rvalid = 1'b0;
        d.pready = 1'b0;
        // apb setup phase: capture read data, answer next cycle
        if (psel && !penable) begin
            d.pready = 1'b1;
            d.pslverr = (sel == 3'h0);
            case (sel)
                3'h1: d.prdata = {29'h0, q.machine_state_reg};
                3'h2: d.prdata = {q.base, 6'h00, q.gmask};
                3'h3: d.prdata = {30'h0, q.ist};
                3'h4: d.prdata = {30'h0, q.imask};
                3'h5: d.prdata = q.fault_ea;
                3'h6: d.prdata = {2'h0, q.seg[paddr[5:2]][25:24], 4'h0, q.seg[paddr[5:2]][23:0]};
                default: d.prdata = 32'h0;
            endcase
        end
        if (psel && penable && q.pready && pwrite) begin
            case (sel)
                3'h1: d.machine_state_reg = pwdata[2:0];
                3'h2: begin
                    d.base = pwdata[31:16];
                    d.gmask = pwdata[9:0];
                end
                3'h3: d.ist = q.ist & ~pwdata[1:0];
                3'h4: d.imask = pwdata[1:0];
                3'h6: d.seg[paddr[5:2]] = {pwdata[SEG_KS], pwdata[SEG_KP], pwdata[23:0]};
                default: d.machine_state_reg = q.machine_state_reg;
            endcase
        end
        // translation sequencer
        case (q.state)
            ST_IDLE: begin
                if (req_valid && q.ready) begin
                    d.ea = req_ea;
                    d.store = req_store;
                    d.instr = req_instr;
                    if (!(req_instr ? q.machine_state_reg[MSR_IR] : q.machine_state_reg[MSR_DR])) begin
                        // real mode: no translation, no protection
                        d.rvalid = 1'b1;
                        d.rpa = req_ea;
                        d.rpf = 1'b0;
                        d.rprot = 1'b0;
                        d.rwimg = WIMG_REAL;
                    end else begin
                        d.state = ST_FETCH0;
                        d.idx = 3'h0;
                        d.mreq = 1'b1;
                        d.mwe = 1'b0;
                        d.maddr = {q.base, (req_ea[21:12] ^ q.seg[req_ea[31:28]][9:0]) & q.gmask, 6'h00};
                    end
                end
            end
            ST_FETCH0: begin
                d.maddr = grp_addr | {26'h0, q.idx, 3'h0};
                if (mem_ack) begin
                    if (hit) begin
                        d.state = ST_FETCH1;
                        d.maddr = grp_addr | {26'h0, q.idx, 3'h4};
                    end else if (q.idx == 3'(GROUP_ENTRIES - 1)) begin
                        d.state = ST_IDLE;
                        d.mreq = 1'b0;
                        d.rvalid = 1'b1;
                        d.rpf = 1'b1;
                        d.rprot = 1'b0;
                        d.rpa = q.ea;
                        pf_ev = 1'b1;
                    end else begin
                        d.idx = q.idx + 3'h1;
                        d.maddr = grp_addr | {26'h0, q.idx + 3'h1, 3'h0};
                    end
                end
            end
            ST_FETCH1: begin
                if (mem_ack) begin
                    d.w1 = mem_rdata;
                    d.rpf = 1'b0;
                    d.rpa = {mem_rdata[31:PAGE_BITS], q.ea[PAGE_BITS-1:0]};
                    d.rwimg = mem_rdata[W1_WIMG+3:W1_WIMG];
                    if (!allow) begin
                        d.state = ST_IDLE;
                        d.mreq = 1'b0;
                        d.rvalid = 1'b1;
                        d.rprot = 1'b1;
                        prot_ev = 1'b1;
                    end else begin
                        d.rprot = 1'b0;
                        d.state = ST_WRBACK;
                        d.mreq = 1'b0;
                    end
                end
            end
            ST_WRBACK: begin
                if (!q.mreq) begin
                    if (w1_new == q.w1) begin
                        d.state = ST_IDLE;
                        d.rvalid = 1'b1;
                    end else begin
                        d.mreq = 1'b1;
                        d.mwe = 1'b1;
                        d.mwdata = w1_new;
                    end
                end else if (mem_ack) begin
                    d.state = ST_IDLE;
                    d.mreq = 1'b0;
                    d.mwe = 1'b0;
                    d.rvalid = 1'b1;
                end
            end
            default: d.state = ST_IDLE;
        endcase
        if (pf_ev || prot_ev) begin
            d.fault_ea = q.ea;
        end
        // a new event wins over a same-cycle clear
        d.ist = d.ist | {prot_ev, pf_ev};
        d.irq = |(d.ist & d.imask);
        d.ready = (d.state == ST_IDLE) && !d.rvalid;
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.state <= ST_IDLE;
            q.machine_state_reg <= MSR_RST;
            q.base <= TBC_BASE_RST;
            q.gmask <= TBC_MASK_RST;
            q.ready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign req_ready = q.ready;
    assign resp_valid = q.rvalid;
    assign resp_pa = q.rpa;
    assign resp_page_fault = q.rpf;
    assign resp_prot_fault = q.rprot;
    assign resp_wimg = q.rwimg;
    assign mem_req = q.mreq;
    assign mem_addr = q.maddr;
    assign mem_we = q.mwe;
    assign mem_wdata = q.mwdata;
    assign irq = q.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_real_passthru: assert property (@(posedge ref_clk) disable iff (!nrst)
        (q.state == ST_IDLE && req_valid && q.ready
         && !(req_instr ? q.machine_state_reg[MSR_IR] : q.machine_state_reg[MSR_DR]))
        |=> resp_valid && resp_pa == $past(req_ea) && !resp_page_fault)
        else $error("real mode address changed");
    a_offset_kept: assert property (@(posedge ref_clk) disable iff (!nrst)
        resp_valid |-> resp_pa[PAGE_BITS-1:0] == q.ea[PAGE_BITS-1:0])
        else $error("page offset altered");
    a_ppn_joined: assert property (@(posedge ref_clk) disable iff (!nrst)
        (q.state == ST_FETCH1 && mem_ack && allow)
        |=> resp_pa[31:PAGE_BITS] == $past(mem_rdata[31:PAGE_BITS]))
        else $error("physical page number wrong");
    a_fault_last: assert property (@(posedge ref_clk) disable iff (!nrst)
        (q.state == ST_FETCH0 && mem_ack && !hit && q.idx == 3'h7)
        |=> resp_valid && resp_page_fault && ist_pf_set)
        else $error("missing page fault");
    a_group_walk: assert property (@(posedge ref_clk) disable iff (!nrst)
        (q.state == ST_FETCH0 && mem_ack && !hit && q.idx != 3'h7)
        |=> q.state == ST_FETCH0 && q.idx == $past(q.idx) + 3'h1)
        else $error("group walk skipped entry");
    a_entry_stride: assert property (@(posedge ref_clk) disable iff (!nrst)
        (mem_req && !mem_we) |-> mem_addr[2:0] == (q.state == ST_FETCH1 ? 3'h4 : 3'h0))
        else $error("entry word misaligned");
    a_ref_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
        (mem_req && mem_we) |-> mem_wdata[W1_R])
        else $error("referenced flag not set");
    a_chg_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
        (mem_req && mem_we) |-> mem_wdata[W1_C] == (q.store | q.w1[W1_C]))
        else $error("changed flag wrong");
    a_wb_flags_only: assert property (@(posedge ref_clk) disable iff (!nrst)
        (mem_req && mem_we) |-> (mem_wdata ^ q.w1) == ((mem_wdata ^ q.w1) & 32'h180))
        else $error("write back altered other bits");
    a_prot_deny: assert property (@(posedge ref_clk) disable iff (!nrst)
        (q.state == ST_FETCH1 && mem_ack && !allow) |=> resp_valid && resp_prot_fault ##1 !mem_we)
        else $error("protection not enforced");

    assign ist_pf_set = q.ist[IRQ_PF];
endmodule // mpt_mmu
`default_nettype wire

// ===== bench/mpt_mem_model.sv
/*
  mpt_mem_model: page table memory behind the translation block.
  assumes: ref_clk domain; request held until ack; 32 words, base 0.
*/
`timescale 1ns/1ps
`default_nettype none
module mpt_mem_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // memory port
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic mem_we,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    // answer delay in cycles
    input wire logic [1:0] dly
);
    // ----------------------------------------
    // storage and answer
    // ----------------------------------------
    logic [31:0] mem [32];
    logic [1:0] cnt;
    // ack no sooner than the second request cycle; idle data toggles
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mem_ack <= 1'b0;
            cnt <= 2'h0;
            mem_rdata <= 32'h0;
        end else if (mem_req && !mem_ack && cnt == dly) begin
            mem_ack <= 1'b1;
            cnt <= 2'h0;
            mem_rdata <= mem[mem_addr[6:2]];
            if (mem_we) begin
                mem[mem_addr[6:2]] <= mem_wdata;
            end
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                cnt <= cnt + 2'h1;
            end
        end
    end
endmodule // mpt_mem_model
`default_nettype wire

// ===== bench/mpt_mmu_tb.sv
/*
  mpt_mmu_tb: self-checking bench for mpt_mmu against a behavioural model.
  assumes: mpt_pkg compiled first; mpt_mem_model as page table memory.
*/
`timescale 1ns/1ps
`default_nettype none
module mpt_mmu_tb import mpt_pkg::*; ();
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic req_valid = 0, req_store = 0, req_instr = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, req_ea = 0;
    logic [1:0] dly = 0;
    logic [31:0] prdata, resp_pa, mem_addr, mem_wdata, mem_rdata;
    logic pready, pslverr, req_ready, resp_valid, resp_page_fault, resp_prot_fault;
    logic mem_req, mem_we, mem_ack, irq, er;
    logic [3:0] resp_wimg;
    logic [31:0] mdl [32];
    logic [31:0] segs [16];
    logic [31:0] rd, ea;
    logic [2:0] machine_state_reg = 0;
    logic [9:0] gmask = 0;
    logic [1:0] sts = 0, msk = 0;
    int err_count = 0, checks_done = 0, cyc = 0;

    mpt_mmu mpt_mmu_i (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req_valid(req_valid), .req_ea(req_ea), .req_store(req_store),
        .req_instr(req_instr), .req_ready(req_ready), .resp_valid(resp_valid),
        .resp_pa(resp_pa), .resp_page_fault(resp_page_fault),
        .resp_prot_fault(resp_prot_fault), .resp_wimg(resp_wimg), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .irq(irq));
    mpt_mem_model mpt_mem_model_i (.ref_clk(ref_clk), .nrst(nrst), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .dly(dly));

    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            summarize();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task summarize();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            $display("wrong value %s exp %h seen %h", n, e, s);
            err_count++;
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) err_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), rd, e);
    endtask
    function int ix(input logic [31:0] a, input logic [31:0] s, input int i);
        return (((a[21:12] ^ s[9:0]) & gmask) * 16 + i * 2) % 32;
    endfunction
    task place(input logic [31:0] a, input int i, input logic [31:0] w1);
        int x;
        x = ix(a, segs[a[31:28]], i);
        mdl[x] = {1'b1, segs[a[31:28]][23:0], 1'b0, a[27:22]};
        mdl[x + 1] = w1;
        mpt_mem_model_i.mem[x] = mdl[x];
        mpt_mem_model_i.mem[x + 1] = w1;
    endtask
    task go(input logic [31:0] a, input logic st, input logic ins);
        logic [31:0] s, w1, pa;
        logic pf, prf, key, ok;
        logic [3:0] wm;
        int x, n;
        pa = a; pf = 1; prf = 0; wm = WIMG_REAL; x = -1; s = segs[a[31:28]];
        if (!(ins ? machine_state_reg[MSR_IR] : machine_state_reg[MSR_DR])) pf = 0;
        else begin
            for (int i = 0; i < GROUP_ENTRIES; i++) begin
                if (x < 0 && mdl[ix(a, s, i)] === {1'b1, s[23:0], 1'b0, a[27:22]}) x = ix(a, s, i);
            end
        end
        if (x >= 0) begin
            pf = 0; w1 = mdl[x + 1]; key = machine_state_reg[MSR_PR] ? s[SEG_KP] : s[SEG_KS];
            case (w1[1:0])
                2'h0: ok = !key;
                2'h1: ok = !key || !st;
                2'h2: ok = 1'b1;
                default: ok = !st;
            endcase
            if (ok) begin
                pa = {w1[31:12], a[11:0]}; wm = w1[6:3]; mdl[x + 1][W1_R] = 1'b1;
                if (st) mdl[x + 1][W1_C] = 1'b1;
            end else prf = 1;
        end
        sts = sts | {prf, pf};
        @(posedge ref_clk);
        req_valid <= 1'b1; req_ea <= a; req_store <= st; req_instr <= ins;
        dly <= 2'($urandom % 4);
        n = 0;
        do begin @(posedge ref_clk); n++; end while (req_ready !== 1'b1 && n < 50);
        if (req_ready !== 1'b1) err_count++;
        req_valid <= 1'b0;
        n = 0;
        do begin @(posedge ref_clk); n++; end while (resp_valid !== 1'b1 && n < 300);
        if (resp_valid !== 1'b1) err_count++;
        chk("page fault", resp_page_fault, pf);
        chk("prot fault", resp_prot_fault, prf);
        if (!pf && !prf) chk("pa", resp_pa, pa);
        if (!pf && !prf) chk("wimg", resp_wimg, wm);
        for (int k = 0; k < 32; k++) chk("table", mpt_mem_model_i.mem[k], mdl[k]);
        repeat (2) @(posedge ref_clk);
        chk("irq", irq, |(sts & msk));
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        void'($urandom(28));
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        chk("ready", req_ready, 1);
        chk("irq", irq, 0);
        for (int k = 0; k < 5; k++) rchk(8'(4 * k), 32'h0);
        apb(1'b1, OFS_FEA, 32'hffff_ffff);
        rchk(OFS_FEA, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", er, 1);
        chk("unmapped", rd, 0);
        for (int k = 0; k < 32; k++) mdl[k] = $urandom;
        for (int k = 0; k < 32; k++) mpt_mem_model_i.mem[k] = mdl[k];
        for (int k = 0; k < NUM_SEG; k++) begin
            segs[k] = $urandom & 32'h30ff_ffff;
            apb(1'b1, OFS_SEG + 8'(4 * k), segs[k]);
        end
        for (int k = 0; k < NUM_SEG; k++) rchk(OFS_SEG + 8'(4 * k), segs[k]);
        repeat (4) go($urandom, 1'($urandom), 1'($urandom));
        apb(1'b1, OFS_IMSK, 32'h3);
        msk = 2'h3;
        for (int t = 0; t < 16; t++) begin
            machine_state_reg = {1'($urandom), 2'h3};
            apb(1'b1, OFS_MSR, {29'h0, machine_state_reg});
            ea = $urandom;
            place(ea, $urandom % 8, $urandom);
            go(ea, 1'($urandom), 1'($urandom));
        end
        rchk(OFS_IST, {30'h0, sts});
        apb(1'b1, OFS_IST, 32'h3);
        sts = 0;
        rchk(OFS_IST, 32'h0);
        for (int k = 0; k < 32; k += 2) mdl[k][W0_V] = 1'b0;
        for (int k = 0; k < 32; k++) mpt_mem_model_i.mem[k] = mdl[k];
        machine_state_reg = 3'h3;
        apb(1'b1, OFS_MSR, 32'h3);
        ea = $urandom;
        go(ea, 1'b1, 1'b0);
        rchk(OFS_IST, 32'h1);
        rchk(OFS_FEA, ea);
        apb(1'b1, OFS_IST, 32'h1);
        sts = 0;
        apb(1'b1, OFS_IMSK, 32'h0);
        msk = 0;
        go($urandom, 1'b0, 1'b0);
        rchk(OFS_IST, 32'h1);
        apb(1'b1, OFS_IST, 32'h1);
        sts = 0;
        machine_state_reg = 3'h2;
        apb(1'b1, OFS_MSR, 32'h2);
        go($urandom, 1'b0, 1'b1);
        apb(1'b1, OFS_TBC, 32'h0000_0001);
        gmask = 10'h1;
        machine_state_reg = 3'h3;
        apb(1'b1, OFS_MSR, 32'h3);
        for (int t = 0; t < 6; t++) begin
            ea = $urandom;
            place(ea, $urandom % 8, $urandom & 32'hffff_fe7a);
            go(ea, 1'($urandom), 1'($urandom));
        end
        summarize();
    end
endmodule // mpt_mmu_tb
`default_nettype wire
